/* bench/ctrl_model.sv */
// Controller-side model answering the host I/O port
`timescale 1ns/1ps
module ctrl_model (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // Function start
    input  wire logic        fnStart,
    input  wire logic [2:0]  fnCode,
    input  wire logic        initStart,
    // Host words
    input  wire logic        wordValid,
    output logic             wordReady,
    // Completion and drive state
    output logic             initDone,
    output logic             fnDone,
    output logic             fnCrcFault,
    output logic [1:0]       drivePresent
);
    import disk_port_pkg::*;
    logic [5:0] stall;
    logic [1:0] nWords;
    assign wordReady    = (stall == 6'h00);
    assign fnCrcFault   = (fnCode == FN_READ);
    assign drivePresent = 2'h1;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stall <= 6'h00;
            nWords <= 2'h0;
            initDone <= 1'b0;
            fnDone <= 1'b0;
        end else begin
            initDone <= initStart;
            fnDone <= (fnStart && fnCode == FN_STATUS)
                || (wordValid && wordReady && nWords == 2'h1 && fnCode == FN_READ);
            stall <= fnStart ? 6'h28 : stall - 6'(stall != 6'h00);
            nWords <= fnStart ? 2'h0 : nWords + 2'(wordValid && wordReady);
        end
    end
endmodule

/* bench/test_disk_host_io_port.sv */
// Self-checking bench for the disk host I/O port
`timescale 1ns/1ps
module test_disk_host_io_port;
    import disk_port_pkg::*;
    logic clk_sys, rst_n, iotValid, busInit, skip, acWrite, acJam, intReq, s;
    logic fnStart, initStart, wordValid, wordReady, initDone, fnDone, fnCrcFault;
    logic clearAllFlags, linkCheckFault, fnDeleted, fnDrive, fnLen8;
    logic [2:0] iotOp, fnCode;
    logic [11:0] acIn, acOut, wordData, v, expW;
    logic [1:0] drivePresent;
    int miscompares, n_checks, nInt, chkOn;
    disk_host_io_port uut (.clk_sys, .rst_n, .iotValid, .iotOp, .acIn, .busInit,
        .clearAllFlags, .skip, .acClear(), .acWrite, .acJam, .acOut, .intReq,
        .modeSelPin(1'b0), .fnStart, .fnCode, .fnDrive, .fnDensity(), .fnLen8,
        .initStart, .wordValid, .wordReady, .wordData, .rdValid(1'b0), .rdReady(),
        .rdData(12'h000), .initDone, .fnDone, .fnCrcFault, .fnDeleted,
        .linkCheckFault, .fnFaultCode(12'h000), .drivePresent, .mediaDensity(2'h0));
    ctrl_model model (.clk_sys, .rst_n, .fnStart, .fnCode, .initStart, .wordValid,
        .wordReady, .initDone, .fnDone, .fnCrcFault, .drivePresent);
    task end_sim;
        if (miscompares == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task chk(string n, logic [11:0] e, logic [11:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask
    task iot(logic [2:0] op, logic [11:0] ac);
        @(posedge clk_sys) #1;
        iotValid = 1'b1;
        iotOp = op;
        acIn = ac;
        @(negedge clk_sys) s = skip;
        @(posedge clk_sys) #1 iotValid = 1'b0;
    endtask
    task until_skip(logic [2:0] op);
        for (int i = 0; i < 300; i++) begin
            iot(op, 12'h000);
            if (s === 1'b1) return;
        end
        miscompares++;
        $display("mismatch skip_op%0d exp 1 got 0", op);
        end_sim;
    endtask
    task rd;
        v = 12'hxxx;
        iot(OP_XDR, 12'h000);
        repeat (4) begin
            if (acWrite === 1'b1) begin
                v = acOut;
                chk("acJam", 12'h001, {11'h0, acJam});
            end
            @(posedge clk_sys) #1;
        end
    endtask
    task t_init;
        iot(OP_INIT, 12'h000);
        until_skip(OP_SDN);
        iot(OP_SDN, 12'h000);
        chk("skip", 12'h000, {11'h0, s});
        rd;
        chk("startup", 12'h001, {11'h0, v[ST_ID]});
        chk("drvrdy", 12'h001, {11'h0, v[ST_RDY]});
    endtask
    task t_irq(logic [11:0] expInt);
        nInt = 0;
        iot(OP_LCD, (12'(FN_STATUS) << CMD_FN_LO) | (12'h001 << CMD_DRV));
        repeat (12) @(posedge clk_sys);
        chk("fnCode", 12'(FN_STATUS), 12'(fnCode));
        chk("fnDrive", 12'h001, {11'h0, fnDrive});
        chk("fnLen8", 12'h000, {11'h0, fnLen8});
        until_skip(OP_SDN);
        chk("intCount", expInt, 12'(nInt));
    endtask
    task t_fill;
        chkOn = 1;
        expW = 12'h500;
        iot(OP_LCD, (12'(FN_FILL) << CMD_FN_LO) | (12'h001 << CMD_DRV));
        chk("fillDrive", 12'h000, {11'h0, fnDrive});
        for (int i = 0; i < 64; i++) begin
            until_skip(OP_STR);
            if (i == 63) iot(OP_SDN, 12'h000);
            if (i == 63) chk("earlyDone", 12'h000, {11'h0, s});
            iot(OP_XDR, 12'h500 + 12'(i));
        end
        until_skip(OP_SDN);
        chk("wordCount", 12'h540, expW);
        chkOn = 0;
    endtask
    task t_crc;
        fnDeleted = 1'b1;
        iot(OP_LCD, 12'(FN_READ) << CMD_FN_LO);
        repeat (2) begin
            until_skip(OP_STR);
            iot(OP_XDR, 12'h001);
        end
        until_skip(OP_SDN);
        until_skip(OP_SER);
        iot(OP_SER, 12'h000);
        chk("serAgain", 12'h000, {11'h0, s});
        rd;
        chk("crcBit", 12'h001, {11'h0, v[ST_CRC]});
        chk("ddBit", 12'h001, {11'h0, v[ST_DD]});
        fnDeleted = 1'b0;
    endtask
    task t_par;
        iot(OP_LCD, 12'(FN_FILL) << CMD_FN_LO);
        linkCheckFault = 1'b1;
        @(posedge clk_sys) #1 linkCheckFault = 1'b0;
        until_skip(OP_SDN);
        until_skip(OP_SER);
        rd;
        chk("parWord", 12'h001 << ST_PAR, v);
    endtask
    task t_clear;
        iot(OP_IRQ_ENABLE_OP, 12'h001);
        clearAllFlags = 1'b1;
        @(posedge clk_sys) #1 clearAllFlags = 1'b0;
        until_skip(OP_SDN);
        t_irq(12'h000);
    endtask
    always @(posedge clk_sys) begin
        if (intReq === 1'b1) nInt++;
        if (chkOn == 1 && wordValid === 1'b1 && wordReady === 1'b1) begin
            chk("wordData", expW, wordData);
            expW++;
        end
    end
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    initial begin
        rst_n = 1'b0;
        iotValid = 1'b0;
        iotOp = OP_NOP;
        acIn = 12'h000;
        busInit = 1'b0;
        clearAllFlags = 1'b0;
        linkCheckFault = 1'b0;
        fnDeleted = 1'b0;
        chkOn = 0;
        repeat (6) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        t_init;
        iot(OP_IRQ_ENABLE_OP, 12'h001);
        t_irq(12'h001);
        @(posedge clk_sys) #1 busInit = 1'b1;
        @(posedge clk_sys) #1 busInit = 1'b0;
        until_skip(OP_SDN);
        t_irq(12'h000);
        t_fill;
        t_crc;
        t_par;
        t_clear;
        end_sim;
    end
endmodule

/* hdl/disk_host_io_port.sv */
// Host I/O port of the flexible disk controller
//
// How it works
// - Fault skip skips, clears; fault always sets finish
// - Finish skip skips on finish, then clears it
// - Interrupt only on finish flag rising edge
// - Enable op loads enable from accumulator bit 11
// - Clear-all, bus and programmed init clear enable
// - Init op and clear-all start init sequence
// - Init ends: status holds startup, drive 0 ready and dual bits
// - One interface register serves six logical words
// - First mode: single command load; bit4 ignored
// - Command bit 5 picks 12 or 8 bits
// - Bit 7 picks drive; buffer functions ignore it
// - Second mode density bit checked against diskette
// - Command bits 8-10 decode the function
// - Code 100: noop clearing startup, or density
// - Eight-bit words use only low eight bits
// - Status word loaded at end except error read
// - Status bits 4 drive present, 5 deleted mark
// - Second mode: bit 6 density, bit 8 dual
// - Second mode: status bit 7 flags density mismatch, fault
// - Status bit 10 flags link check fault
// - Status bit 11 flags read check error
// - Request skip skips on request, then clears
// - Transfer after finish reads status word
`timescale 1ns/1ps
module disk_host_io_port (
    // Clock and reset
    input  wire logic                                clk_sys,
    input  wire logic                                rst_n,
    // Host I/O bus
    input  wire logic                                iotValid,
    input  wire logic [2:0]                          iotOp,
    input  wire logic [disk_port_pkg::WORD_W-1:0]    acIn,
    input  wire logic                                busInit,
    input  wire logic                                clearAllFlags,
    output logic                                     skip,
    output logic                                     acClear,
    output logic                                     acWrite,
    output logic                                     acJam,
    output logic      [disk_port_pkg::WORD_W-1:0]    acOut,
    output logic                                     intReq,
    // Compatibility mode strap pin, high for the second mode
    input  wire logic                                modeSelPin,
    // Controller side: function start
    output logic                                     fnStart,
    output logic      [2:0]                          fnCode,
    output logic                                     fnDrive,
    output logic                                     fnDensity,
    output logic                                     fnLen8,
    output logic                                     initStart,
    // Controller side: words from host (fill data, sector, track)
    output logic                                     wordValid,
    input  wire logic                                wordReady,
    output logic      [disk_port_pkg::WORD_W-1:0]    wordData,
    // Controller side: words to host (empty buffer)
    input  wire logic                                rdValid,
    output logic                                     rdReady,
    input  wire logic [disk_port_pkg::WORD_W-1:0]    rdData,
    // Controller side: completion and drive state
    input  wire logic                                initDone,
    input  wire logic                                fnDone,
    input  wire logic                                fnCrcFault,
    input  wire logic                                fnDeleted,
    input  wire logic                                linkCheckFault,
    input  wire logic [disk_port_pkg::WORD_W-1:0]    fnFaultCode,
    input  wire logic [1:0]                          drivePresent,
    input  wire logic [1:0]                          mediaDensity
);
    import disk_port_pkg::*;

    typedef enum logic [2:0] {S_IDLE, S_CMDHI, S_SECTOR, S_TRACK, S_FILL, S_EMPTY, S_BUSY, S_INIT} state_t;

    function automatic logic [CNT_W-1:0] wordTarget(input logic dual, input logic len8, input logic dbl);
        logic [CNT_W-1:0] base;
        base = len8 ? WORDS_8 : WORDS_12;
        return (dual & dbl) ? CNT_W'({base, 1'b0}) : base;
    endfunction

    state_t              state_reg;
    state_t              state_next;
    logic [WORD_W-1:0]   cmd_reg;
    logic [WORD_W-1:0]   iface_reg;
    logic [WORD_W-1:0]   iface_next;
    logic [CNT_W-1:0]    count_reg;
    logic                done_reg;
    logic                err_reg;
    logic                tr_reg;
    logic                ie_reg;
    logic                loaded_reg;
    logic                idBit_reg;
    logic [2:0]          modeSync_reg;
    logic                dual_reg;
    logic                fnStart_reg;
    logic                initStart_reg;
    logic                intReq_reg;
    logic [WORD_W-1:0]   acOut_reg;
    logic                acWrite_reg;
    logic                acJam_reg;

    // Instruction decode
    wire isLcd  = iotValid & (iotOp == OP_LCD);
    wire isXdr  = iotValid & (iotOp == OP_XDR);
    wire isStr  = iotValid & (iotOp == OP_STR);
    wire isSer  = iotValid & (iotOp == OP_SER);
    wire isSdn  = iotValid & (iotOp == OP_SDN);
    wire isIntr = iotValid & (iotOp == OP_IRQ_ENABLE_OP);
    wire isInit = iotValid & (iotOp == OP_INIT);
    wire initAll = isInit | clearAllFlags | busInit;

    // Command fields
    wire [2:0] cmdFn   = cmd_reg[CMD_FN_LO +: 3];
    wire       cmdLen8 = cmd_reg[CMD_LEN8];
    wire       cmdDrv  = cmd_reg[CMD_DRV];
    wire       cmdDen  = dual_reg & cmd_reg[CMD_DEN];
    wire [2:0] acFn    = acIn[CMD_FN_LO +: 3];
    wire       needHi  = dual_reg & acIn[CMD_LEN8];
    wire       needsAddr = (cmdFn == FN_WRITE) | (cmdFn == FN_READ) | (cmdFn == FN_WRDEL);
    wire       selDen  = mediaDensity[cmdDrv];
    wire       densBad = (selDen != cmdDen);

    // Words written by the host, masked to eight bits when selected
    wire [WORD_W-1:0] hostWord = cmdLen8 ? {4'h0, acIn[7:0]} : acIn;
    wire              fifoInReady;
    wire              hostToCtl = (state_reg == S_FILL) | (state_reg == S_SECTOR) | (state_reg == S_TRACK);
    wire              xdrIn  = isXdr & !done_reg & hostToCtl & loaded_reg;
    wire              xdrOut = isXdr & (done_reg | (state_reg == S_IDLE) |
                                        ((state_reg == S_EMPTY) & loaded_reg));
    wire              xdrHi  = isXdr & (state_reg == S_CMDHI) & loaded_reg;
    wire              wantWord = ((state_reg == S_FILL) | (state_reg == S_SECTOR) | (state_reg == S_TRACK) |
                                  (state_reg == S_CMDHI)) & !loaded_reg & fifoInReady;
    assign rdReady = (state_reg == S_EMPTY) & !loaded_reg & !initAll;
    wire              takeRd = rdValid & rdReady;
    wire [CNT_W-1:0]  target = wordTarget(dual_reg, cmdLen8, cmdDen);
    wire              lastWord = (count_reg + CNT_W'(1)) == target;

    // Status word composed at the end of a function
    wire [WORD_W-1:0] statusWord;
    assign statusWord[11:8]      = 4'h0;
    assign statusWord[ST_RDY]    = (cmdFn == FN_STATUS) & drivePresent[cmdDrv];
    assign statusWord[ST_DD]     = fnDeleted | (cmdFn == FN_WRDEL);
    assign statusWord[ST_DEN]    = dual_reg & selDen;
    assign statusWord[ST_DENERR] = dual_reg & needsAddr & densBad;
    assign statusWord[ST_DUAL]   = dual_reg;
    assign statusWord[ST_ID]     = idBit_reg;
    assign statusWord[ST_PAR]    = 1'b0;
    assign statusWord[ST_CRC]    = fnCrcFault & (cmdFn == FN_READ);
    wire [WORD_W-1:0] initWord = (WORD_W'(1) << ST_ID) | (WORD_W'(drivePresent[0]) << ST_RDY) |
                                 (WORD_W'(dual_reg) << ST_DUAL);
    wire [WORD_W-1:0] parWord  = (WORD_W'(1) << ST_PAR) | (WORD_W'(dual_reg) << ST_DUAL);
    wire [WORD_W-1:0] denWord  = (WORD_W'(dual_reg) << ST_DENERR) | (WORD_W'(dual_reg & selDen) << ST_DEN) |
                                 (WORD_W'(dual_reg) << ST_DUAL);

    // Finish and fault events
    wire busyFin   = (state_reg == S_BUSY) & fnDone;
    wire parFin    = linkCheckFault & (state_reg != S_IDLE) & (state_reg != S_INIT);
    wire denFin    = xdrIn & (state_reg == S_TRACK) & densBad & (dual_reg | selDen);
    wire fillFin   = xdrIn & (state_reg == S_FILL) & lastWord;
    wire emptyFin  = xdrOut & !done_reg & (state_reg == S_EMPTY) & lastWord;
    wire noopFin   = xdrHi ? 1'b0 : (isLcd & (state_reg == S_IDLE) & !needHi & !dual_reg & (acFn == FN_NOOP_DEN));
    wire initFin   = (state_reg == S_INIT) & initDone;
    wire doneSet   = busyFin | parFin | denFin | fillFin | emptyFin | noopFin | initFin;
    wire errSet    = parFin | denFin | (busyFin & statusWord[ST_CRC]);
    wire trSet     = wantWord | takeRd;

    // Next state of the function sequencer
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            S_IDLE: begin
                if (isLcd & needHi) begin
                    state_next = S_CMDHI;
                end else if (isLcd & !noopFin) begin
                    state_next = (acFn == FN_FILL) ? S_FILL : (acFn == FN_EMPTY) ? S_EMPTY :
                                 ((acFn == FN_WRITE) | (acFn == FN_READ) | (acFn == FN_WRDEL)) ? S_SECTOR : S_BUSY;
                end
            end
            S_CMDHI: begin
                if (xdrHi) begin
                    state_next = (cmdFn == FN_FILL) ? S_FILL : (cmdFn == FN_EMPTY) ? S_EMPTY :
                                 needsAddr ? S_SECTOR : S_BUSY;
                end
            end
            S_SECTOR: begin
                if (xdrIn) begin
                    state_next = S_TRACK;
                end
            end
            S_TRACK: begin
                if (xdrIn) begin
                    state_next = denFin ? S_IDLE : S_BUSY;
                end
            end
            S_FILL: begin
                if (fillFin) begin
                    state_next = S_IDLE;
                end
            end
            S_EMPTY: begin
                if (emptyFin) begin
                    state_next = S_IDLE;
                end
            end
            S_BUSY: begin
                if (busyFin) begin
                    state_next = S_IDLE;
                end
            end
            S_INIT: begin
                if (initFin) begin
                    state_next = S_IDLE;
                end
            end
        endcase
        if (parFin) begin
            state_next = S_IDLE;
        end
        if (initAll) begin
            state_next = S_INIT;
        end
    end

    // Interface register contents, one physical word for all logical ones
    always_comb begin
        iface_next = iface_reg;
        if (isLcd & (state_reg == S_IDLE)) begin
            iface_next = acIn;
        end else if (xdrIn | xdrHi) begin
            iface_next = hostWord;
        end else if (takeRd) begin
            iface_next = cmdLen8 ? {4'h0, rdData[7:0]} : rdData;
        end
        if (initFin) begin
            iface_next = initWord;
        end else if (parFin) begin
            iface_next = parWord;
        end else if (denFin) begin
            iface_next = denWord;
        end else if (busyFin) begin
            iface_next = (cmdFn == FN_RDERR) ? fnFaultCode : statusWord;
        end else if (fillFin | emptyFin | noopFin) begin
            iface_next = statusWord & ~(WORD_W'(noopFin) << ST_ID);
        end
    end

    // Strap synchroniser: a change counts once stages two and three agree
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            modeSync_reg <= 3'h0;
            dual_reg     <= 1'b0;
        end else begin
            modeSync_reg <= {modeSync_reg[1:0], modeSelPin};
            if (modeSync_reg[1] == modeSync_reg[2]) begin
                dual_reg <= modeSync_reg[2];
            end
        end
    end

    // Host-visible flags; a set in the same cycle as a skip wins
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            done_reg <= 1'b0;
            err_reg  <= 1'b0;
            tr_reg   <= 1'b0;
            ie_reg   <= 1'b0;
        end else if (initAll) begin
            done_reg <= 1'b0;
            err_reg  <= 1'b0;
            tr_reg   <= 1'b0;
            ie_reg   <= 1'b0;
        end else begin
            done_reg <= doneSet | (done_reg & !isSdn & !(isLcd & (state_reg == S_IDLE)));
            err_reg  <= errSet | (err_reg & !isSer);
            tr_reg   <= trSet | (tr_reg & !isStr & !doneSet);
            ie_reg   <= isIntr ? acIn[AC_IE] : ie_reg;
        end
    end

    // Sequencer registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_reg  <= S_IDLE;
            cmd_reg    <= 12'h000;
            iface_reg  <= STATUS_RST;
            count_reg  <= '0;
            loaded_reg <= 1'b0;
            idBit_reg  <= 1'b0;
        end else begin
            state_reg  <= state_next;
            iface_reg  <= iface_next;
            if (isLcd & (state_reg == S_IDLE)) begin
                cmd_reg <= acIn;
            end else if (xdrHi) begin
                cmd_reg[11:8] <= acIn[3:0];
            end
            if (initAll | (state_next != state_reg)) begin
                count_reg <= '0;
            end else if (fillFin | emptyFin) begin
                count_reg <= count_reg;
            end else if (xdrIn | (xdrOut & (state_reg == S_EMPTY))) begin
                count_reg <= count_reg + CNT_W'(1);
            end
            loaded_reg <= !initAll & (trSet | (loaded_reg & !(xdrIn | xdrHi | xdrOut)) | (state_next != state_reg ? 1'b0 : 1'b0));
            if (initFin) begin
                idBit_reg <= 1'b1;
            end else if (isLcd & (state_reg == S_IDLE)) begin
                idBit_reg <= 1'b0;
            end
        end
    end

    // Controller strobes, accumulator path and interrupt
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fnStart_reg   <= 1'b0;
            initStart_reg <= 1'b0;
            intReq_reg    <= 1'b0;
            acOut_reg     <= 12'h000;
            acWrite_reg   <= 1'b0;
            acJam_reg     <= 1'b0;
        end else begin
            fnStart_reg   <= ((state_reg == S_IDLE) & isLcd & !needHi & !noopFin) | xdrHi;
            initStart_reg <= initAll;
            intReq_reg    <= ie_reg & doneSet & !done_reg & !initAll;
            acWrite_reg   <= xdrOut;
            acJam_reg     <= !cmdLen8;
            if (xdrOut) begin
                acOut_reg <= iface_reg;
            end
        end
    end

    word_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .inValid  (xdrIn),
        .inReady  (fifoInReady),
        .inData   (hostWord),
        .outValid (wordValid),
        .outReady (wordReady),
        .outData  (wordData)
    );

    assign skip      = (isSer & err_reg) | (isSdn & done_reg) | (isStr & tr_reg);
    assign acClear   = isLcd;
    assign acWrite   = acWrite_reg;
    assign acJam     = acJam_reg;
    assign acOut     = acOut_reg;
    assign intReq    = intReq_reg;
    assign fnStart   = fnStart_reg;
    assign fnCode    = cmdFn;
    assign fnDrive   = cmdDrv & (cmdFn != FN_FILL) & (cmdFn != FN_EMPTY);
    assign fnDensity = cmdDen;
    assign fnLen8    = cmdLen8;
    assign initStart = initStart_reg;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_err_with_done: assert property (errSet & !initAll |=> err_reg & done_reg) else $error("fault alone");
    a_sdn_clears: assert property (isSdn & !doneSet & !initAll |=> !done_reg) else $error("finish kept");
    a_irq_edge: assert property (intReq |-> done_reg & !$past(done_reg)) else $error("irq not on edge");
    a_irq_once: assert property (intReq |=> !intReq) else $error("irq repeated");
    a_ie_load: assert property (isIntr & !initAll |=> ie_reg == $past(acIn[AC_IE])) else $error("enable");
    a_init_clr_ie: assert property (initAll |=> !ie_reg ##0 state_reg == S_INIT) else $error("init");
    a_init_id: assert property (initFin & !initAll |=>
        iface_reg[ST_ID] & done_reg & !err_reg) else $error("startup");
    a_par_end: assert property (parFin & !initAll |=> err_reg & done_reg & iface_reg[ST_PAR]) else $error("par");
    a_den_end: assert property (denFin & !initAll & !parFin |=>
        err_reg & done_reg & (iface_reg[ST_DENERR] == dual_reg)) else $error("den");
    a_fill_drv: assert property (cmdFn == FN_FILL |-> !fnDrive) else $error("drive on fill");
    a_err_hold: assert property (err_reg & !isSer & !initAll |=> err_reg) else $error("fault lost");
    a_word_8bit: assert property (wordValid & cmdLen8 |-> wordData[11:8] == 4'h0) else $error("8-bit");

    c_fill_done: cover property (fillFin ##1 done_reg);
    c_read_crc: cover property (busyFin & statusWord[ST_CRC]);
    c_init_irq: cover property (isIntr ##[1:50] intReq);
    c_fifo_full: cover property (state_reg == S_FILL && !fifoInReady);
endmodule

/* hdl/disk_port_pkg.sv */
// Shared constants for the disk host I/O port
package disk_port_pkg;
    localparam int          WORD_W      = 12;
    localparam int          CNT_W       = 9;
    // I/O instruction op codes
    localparam logic [2:0]  OP_NOP      = 3'h0;
    localparam logic [2:0]  OP_LCD      = 3'h1;
    localparam logic [2:0]  OP_XDR      = 3'h2;
    localparam logic [2:0]  OP_STR      = 3'h3;
    localparam logic [2:0]  OP_SER      = 3'h4;
    localparam logic [2:0]  OP_SDN      = 3'h5;
    localparam logic [2:0]  OP_IRQ_ENABLE_OP     = 3'h6;
    localparam logic [2:0]  OP_INIT     = 3'h7;
    // Command word fields (bit 11 of the host numbering is bit 0 here)
    localparam int          CMD_DEN     = 8;
    localparam int          CMD_LEN8    = 6;
    localparam int          CMD_DRV     = 4;
    localparam int          CMD_FN_LO   = 1;
    localparam int          AC_IE       = 0;
    // Function codes
    localparam logic [2:0]  FN_FILL     = 3'h0;
    localparam logic [2:0]  FN_EMPTY    = 3'h1;
    localparam logic [2:0]  FN_WRITE    = 3'h2;
    localparam logic [2:0]  FN_READ     = 3'h3;
    localparam logic [2:0]  FN_NOOP_DEN = 3'h4;
    localparam logic [2:0]  FN_STATUS   = 3'h5;
    localparam logic [2:0]  FN_WRDEL    = 3'h6;
    localparam logic [2:0]  FN_RDERR    = 3'h7;
    // Fault/status word bit positions
    localparam int          ST_RDY      = 7;
    localparam int          ST_DD       = 6;
    localparam int          ST_DEN      = 5;
    localparam int          ST_DENERR   = 4;
    localparam int          ST_DUAL     = 3;
    localparam int          ST_ID       = 2;
    localparam int          ST_PAR      = 1;
    localparam int          ST_CRC      = 0;
    localparam logic [11:0] STATUS_RST  = 12'h000;
    // Words per buffer transfer in single density
    localparam logic [8:0]  WORDS_8     = 9'h080;
    localparam logic [8:0]  WORDS_12    = 9'h040;
    localparam int          FIFO_DEPTH  = 8;
endpackage

/* hdl/word_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module word_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    // Fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wrPtr_reg;
    logic [AW:0]      rdPtr_reg;
    wire              pushOk = inValid & inReady;
    wire              popOk  = outValid & outReady;
    assign inReady  = (wrPtr_reg - rdPtr_reg) != (AW+1)'(DEPTH);
    assign outValid = wrPtr_reg != rdPtr_reg;
    assign outData  = mem[rdPtr_reg[AW-1:0]];
    always_ff @(posedge clk_sys) begin
        if (pushOk) begin
            mem[wrPtr_reg[AW-1:0]] <= inData;
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
        end else begin
            wrPtr_reg <= wrPtr_reg + (AW+1)'(pushOk);
            rdPtr_reg <= rdPtr_reg + (AW+1)'(popOk);
        end
    end
endmodule
